// ===== design/ctbcd_pkg.sv
package ctbcd_pkg;

  // ************************************************************
  // widths and register offsets
  // ************************************************************
  localparam int CW = 24;
  localparam logic [7:0] ADR_CTRLA = 8'h00;
  localparam logic [7:0] ADR_CTRLB_CLR = 8'h04;
  localparam logic [7:0] ADR_CTRLB_SET = 8'h08;
  localparam logic [7:0] ADR_EVCTRL = 8'h0c;
  localparam logic [7:0] ADR_DRV = 8'h10;
  localparam logic [7:0] ADR_STATUS = 8'h14;
  localparam logic [7:0] ADR_INTFLAG = 8'h18;
  localparam logic [7:0] ADR_WAVE = 8'h1c;
  localparam logic [7:0] ADR_WAVEFORM_CONTROL_BUFFER = 8'h20;
  localparam logic [7:0] ADR_OUTPUT_PATTERN = 8'h24;
  localparam logic [7:0] ADR_OUTPUT_PATTERN_BUFFER = 8'h28;
  localparam logic [7:0] ADR_COUNT = 8'h2c;
  localparam logic [7:0] ADR_PER = 8'h30;
  localparam logic [7:0] ADR_PERIOD_BUFFER = 8'h34;
  localparam logic [3:0] ADR_CC_PAGE = 4'h4;
  localparam logic [3:0] ADR_CCB_PAGE = 4'h5;

  // ************************************************************
  // field positions
  // ************************************************************
  localparam int A_EN = 0;
  localparam int A_RES = 1;
  localparam int A_MODE = 4;
  localparam int A_CPTEN = 8;
  localparam int B_DIR = 0;
  localparam int B_LOCK = 1;
  localparam int B_SINGLE = 2;
  localparam int B_RETRIG = 3;
  localparam int E_EV0ACT = 0;
  localparam int E_EV1ACT = 2;
  localparam int E_INV1 = 4;
  localparam int E_MCEI = 8;
  localparam int D_NRE = 0;
  localparam int D_NRV = 8;
  localparam int S_STOP = 0;
  localparam int S_PERIOD_BUFFER_VALID = 1;
  localparam int S_WAVEFORM_BUFFER_VALID = 2;
  localparam int S_PATTERN_BUFFER_VALID = 3;
  localparam int S_CCBV = 4;
  localparam int I_OVF = 0;
  localparam int I_ERR = 1;
  localparam int I_MC = 4;
  localparam int W_CIPER = 0;
  localparam int W_CICC = 1;
  localparam int P_VAL = 8;

  // ************************************************************
  // codes, reset values and timing counts
  // ************************************************************
  localparam logic [2:0] MODE_NORMAL_FREQUENCY_MODE = 3'h0;
  localparam logic [2:0] MODE_MATCH_FREQUENCY_MODE = 3'h1;
  localparam logic [2:0] MODE_NPWM = 3'h2;
  localparam logic [2:0] MODE_DSBOTH = 3'h3;
  localparam logic [1:0] RES_NONE = 2'h0;
  localparam logic [1:0] RES_DITHER_16_FRAME = 2'h1;
  localparam logic [1:0] RES_DITHER_32_FRAME = 2'h2;
  localparam logic [1:0] RES_DITHER_64_FRAME = 2'h3;
  localparam logic [5:0] MASK_16 = 6'h0f;
  localparam logic [5:0] MASK_32 = 6'h1f;
  localparam logic [5:0] MASK_64 = 6'h3f;
  localparam logic [1:0] EV0_RETRIGGER = 2'h1;
  localparam logic [1:0] EV0_START = 2'h2;
  localparam logic [1:0] EV1_PERIOD_THEN_WIDTH = 2'h1;
  localparam logic [1:0] EV1_WIDTH_THEN_PERIOD = 2'h2;
  localparam logic [CW-1:0] RST_PER = 24'hffffff;
  localparam logic [CW-1:0] MAX_HALF = 24'h800000;
  localparam logic [1:0] PER_SYNC_CYCLES = 2'h2;

  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    RUN_IDLE = 3'b001,
    RUN_COUNT = 3'b010,
    RUN_STOPPED = 3'b100
  } ctbcd_run_e;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } ctbcd_wb_req_s;

endpackage : ctbcd_pkg

// ===== design/ctbcd_top.sv
`timescale 1ns/1ps
// Function
// [R01] pattern, waveform, period, compare each have buffer+valid
// [R02] buffer write sets valid; update clears it
// [R03] update lock bypasses buffering, direct writes
// [R04] frequency/down modes load period with buffer
// [R05] unbuffered period write applies after sync delay
// [R06] equality top compare, lower top wraps
// [R07] buffered period copied on update, or on lock clear in frequency/down modes
// [R08] software enables event input and capture channel
// [R09] each enabled channel captures count on event
// [R10] compare and buffer form two-entry capture queue
// [R11] capture with flag and valid sets error
// [R12] period/width order into channels 0 and 1
// [R13] both edges captured, chosen edge restarts
// [R14] dual slope small top: MSB holds direction
// [R15] single run stops at wrap, halt outputs
// [R16] single run set/clear via control B
// [R17] retrigger or start restarts, clears stopped
// [R18] circular buffer swaps active and buffer
// [R19] dither frames of 16, 32, 64 cycles
// [R20] low bits hold extra-cycle count
// [R21] extra clock when masked product overflows
// [R22] capture overflow drops the new timestamp
module ctbcd_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input ctbcd_pkg::ctbcd_wb_req_s wb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // asynchronous events: [0] timer event 0, [1] timer event 1, [5:2] channel events
  input wire logic [5:0] event_i,
  // waveform outputs
  output logic [3:0] waveform_o
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    ctbcd_pkg::ctbcd_run_e run;
    logic [15:0] ctrla;
    logic [2:0] ctrlb;
    logic [15:0] evctrl;
    logic [15:0] drive_control;
    logic stop;
    logic period_buffer_valid;
    logic waveform_buffer_valid;
    logic pattern_buffer_valid;
    logic [3:0] compare_buffer_valid;
    logic ovf;
    logic error_interrupt_flag;
    logic [3:0] channel_match_flag;
    logic [7:0] wave;
    logic [7:0] waveform_control_buffer;
    logic [15:0] output_pattern;
    logic [15:0] output_pattern_buffer;
    logic [23:0] count;
    logic ramp_down;
    logic [23:0] per;
    logic [23:0] period_buffer;
    logic [3:0][23:0] compare_channel;
    logic [3:0][23:0] compare_buffer;
    logic per_pend;
    logic [23:0] per_pend_val;
    logic [1:0] per_pend_cnt;
    logic [5:0] frame;
    logic [5:0] ev_s1;
    logic [5:0] ev_s2;
    logic [5:0] ev_s3;
    logic [3:0] wo;
    logic [3:0] out;
  } ctbcd_state_s;

  ctbcd_state_s s;
  ctbcd_state_s next_s;

  // ************************************************************
  // helpers
  // ************************************************************
  // number of low bits taken by the extra-cycle count
  function automatic logic [2:0] dith_shift(input logic [1:0] res);
    case (res)
      ctbcd_pkg::RES_DITHER_16_FRAME: dith_shift = 3'h4;
      ctbcd_pkg::RES_DITHER_32_FRAME: dith_shift = 3'h5;
      ctbcd_pkg::RES_DITHER_64_FRAME: dith_shift = 3'h6;
      default: dith_shift = 3'h0;
    endcase
  endfunction : dith_shift

  // one extra clock in this frame cycle or not
  function automatic logic extra_cycle(input logic [1:0] res, input logic [23:0] v, input logic [5:0] cyc);
    logic [5:0] mask;
    logic [5:0] dcy;
    logic [11:0] prod;
    logic [6:0] sum;
    case (res)
      ctbcd_pkg::RES_DITHER_16_FRAME: mask = ctbcd_pkg::MASK_16;
      ctbcd_pkg::RES_DITHER_32_FRAME: mask = ctbcd_pkg::MASK_32;
      ctbcd_pkg::RES_DITHER_64_FRAME: mask = ctbcd_pkg::MASK_64;
      default: mask = 6'h00;
    endcase
    dcy = v[5:0] & mask; // see [R20]
    prod = cyc * dcy;
    sum = {1'b0, mask & prod[5:0]} + {1'b0, dcy};
    extra_cycle = (res != ctbcd_pkg::RES_NONE) && (sum > {1'b0, mask}); // see [R21]
  endfunction : extra_cycle

  // byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = sel[b] ? d[8*b +: 8] : old[8*b +: 8];
    end
  endfunction : merge

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [2:0] sh;
    logic [1:0] res;
    logic [2:0] mode;
    logic [3:0] cpten;
    logic [5:0] rise;
    logic [5:0] fall;
    logic [23:0] top;
    logic [23:0] wd;
    logic [23:0] cmp;
    logic [23:0] cap_val;
    logic [3:0] cap;
    logic wr;
    logic rd;
    logic wrap;
    logic upd;
    logic restart;
    logic pw_restart;
    logic pw_other;
    logic freq_mode;
    logic [1:0] ci;
    logic [31:0] wd32;
    logic [31:0] mg;
    next_s = s;
    res = s.ctrla[ctbcd_pkg::A_RES +: 2];
    mode = s.ctrla[ctbcd_pkg::A_MODE +: 3];
    cpten = s.ctrla[ctbcd_pkg::A_CPTEN +: 4];
    sh = dith_shift(res);
    freq_mode = (mode == ctbcd_pkg::MODE_NORMAL_FREQUENCY_MODE) || (mode == ctbcd_pkg::MODE_MATCH_FREQUENCY_MODE);
    top = (mode == ctbcd_pkg::MODE_MATCH_FREQUENCY_MODE) ? s.compare_channel[0] : s.per;
    top = (top >> sh) + {23'h000000, extra_cycle(res, top, s.frame)}; // see [R19]
    wr = s.ack & wb_i.cyc & wb_i.stb & wb_i.we;
    rd = s.ack & wb_i.cyc & wb_i.stb & ~wb_i.we;
    wd32 = merge(32'h00000000, wb_i.dat, wb_i.sel);
    wd = wd32[23:0];
    mg = 32'h00000000;
    ci = wb_i.adr[3:2];
    restart = 1'b0;
    wrap = 1'b0;
    upd = 1'b0;
    cap = 4'h0;
    cmp = 24'h000000;
    // two-flop synchronisers, third stage for edges
    next_s.ev_s1 = event_i;
    next_s.ev_s2 = s.ev_s1;
    next_s.ev_s3 = s.ev_s2;
    rise = s.ev_s2 & ~s.ev_s3;
    fall = ~s.ev_s2 & s.ev_s3;
    // bus handshake and registered read data
    next_s.ack = wb_i.cyc & wb_i.stb & ~s.ack;
    next_s.dat = 32'h00000000;
    if (wb_i.adr[7:4] == ctbcd_pkg::ADR_CC_PAGE) begin
      next_s.dat = {8'h00, s.compare_channel[ci]};
    end else if (wb_i.adr[7:4] == ctbcd_pkg::ADR_CCB_PAGE) begin
      next_s.dat = {8'h00, s.compare_buffer[ci]};
    end else begin
      case (wb_i.adr)
        ctbcd_pkg::ADR_CTRLA: next_s.dat = {16'h0000, s.ctrla};
        ctbcd_pkg::ADR_CTRLB_CLR, ctbcd_pkg::ADR_CTRLB_SET: next_s.dat = {29'h00000000, s.ctrlb};
        ctbcd_pkg::ADR_EVCTRL: next_s.dat = {16'h0000, s.evctrl};
        ctbcd_pkg::ADR_DRV: next_s.dat = {16'h0000, s.drive_control};
        ctbcd_pkg::ADR_STATUS: next_s.dat = {24'h000000, s.compare_buffer_valid, s.pattern_buffer_valid,
                                             s.waveform_buffer_valid, s.period_buffer_valid, s.stop};
        ctbcd_pkg::ADR_INTFLAG: next_s.dat = {24'h000000, s.channel_match_flag, 2'h0,
                                              s.error_interrupt_flag, s.ovf};
        ctbcd_pkg::ADR_WAVE: next_s.dat = {24'h000000, s.wave};
        ctbcd_pkg::ADR_WAVEFORM_CONTROL_BUFFER: next_s.dat = {24'h000000, s.waveform_control_buffer};
        ctbcd_pkg::ADR_OUTPUT_PATTERN: next_s.dat = {16'h0000, s.output_pattern};
        ctbcd_pkg::ADR_OUTPUT_PATTERN_BUFFER: next_s.dat = {16'h0000, s.output_pattern_buffer};
        ctbcd_pkg::ADR_COUNT: next_s.dat = {8'h00, s.count << sh};
        ctbcd_pkg::ADR_PER: next_s.dat = {8'h00, s.per};
        ctbcd_pkg::ADR_PERIOD_BUFFER: next_s.dat = {8'h00, s.period_buffer};
        default: next_s.dat = 32'h00000000;
      endcase
    end
    // register writes, taken at the acknowledging edge
    if (wr) begin
      if (wb_i.adr[7:4] == ctbcd_pkg::ADR_CC_PAGE) begin
        next_s.compare_channel[ci] = wd; // see [R03]
      end else if (wb_i.adr[7:4] == ctbcd_pkg::ADR_CCB_PAGE) begin
        next_s.compare_buffer[ci] = wd;
        if (!s.ctrlb[ctbcd_pkg::B_LOCK] && !cpten[ci]) begin
          next_s.compare_buffer_valid[ci] = 1'b1; // see [R02]
        end
      end else begin
        case (wb_i.adr)
          ctbcd_pkg::ADR_CTRLA: begin
            mg = merge({16'h0000, s.ctrla}, wb_i.dat, wb_i.sel);
            next_s.ctrla = mg[15:0];
          end
          ctbcd_pkg::ADR_CTRLB_CLR: begin
            next_s.ctrlb = s.ctrlb & ~wb_i.dat[2:0]; // see [R16]
            if (s.ctrlb[ctbcd_pkg::B_LOCK] && wb_i.dat[ctbcd_pkg::B_LOCK]
                && (freq_mode || s.ctrlb[ctbcd_pkg::B_DIR])) begin
              next_s.per = s.period_buffer; // see [R04]
              next_s.period_buffer_valid = 1'b0;
            end
          end
          ctbcd_pkg::ADR_CTRLB_SET: begin
            next_s.ctrlb = s.ctrlb | wb_i.dat[2:0]; // see [R16]
            restart = wb_i.dat[ctbcd_pkg::B_RETRIG]; // see [R17]
          end
          ctbcd_pkg::ADR_EVCTRL: begin
            mg = merge({16'h0000, s.evctrl}, wb_i.dat, wb_i.sel);
            next_s.evctrl = mg[15:0];
          end
          ctbcd_pkg::ADR_DRV: begin
            mg = merge({16'h0000, s.drive_control}, wb_i.dat, wb_i.sel);
            next_s.drive_control = mg[15:0];
          end
          ctbcd_pkg::ADR_INTFLAG: begin
            next_s.ovf = s.ovf & ~wb_i.dat[ctbcd_pkg::I_OVF];
            next_s.error_interrupt_flag = s.error_interrupt_flag & ~wb_i.dat[ctbcd_pkg::I_ERR];
            next_s.channel_match_flag = s.channel_match_flag & ~wb_i.dat[ctbcd_pkg::I_MC +: 4];
          end
          ctbcd_pkg::ADR_WAVE: next_s.wave = wd[7:0];
          ctbcd_pkg::ADR_WAVEFORM_CONTROL_BUFFER: begin
            next_s.waveform_control_buffer = wd[7:0];
            next_s.waveform_buffer_valid = ~s.ctrlb[ctbcd_pkg::B_LOCK]; // see [R01]
          end
          ctbcd_pkg::ADR_OUTPUT_PATTERN: next_s.output_pattern = wd[15:0];
          ctbcd_pkg::ADR_OUTPUT_PATTERN_BUFFER: begin
            next_s.output_pattern_buffer = wd[15:0];
            next_s.pattern_buffer_valid = ~s.ctrlb[ctbcd_pkg::B_LOCK]; // see [R01]
          end
          ctbcd_pkg::ADR_COUNT: next_s.count = wd >> sh;
          ctbcd_pkg::ADR_PER: begin
            next_s.per_pend = 1'b1; // see [R05]
            next_s.per_pend_val = wd;
            next_s.per_pend_cnt = ctbcd_pkg::PER_SYNC_CYCLES;
          end
          ctbcd_pkg::ADR_PERIOD_BUFFER: begin
            next_s.period_buffer = wd;
            if (!s.ctrlb[ctbcd_pkg::B_LOCK]) begin
              if (freq_mode || s.ctrlb[ctbcd_pkg::B_DIR]) begin
                next_s.per = wd; // see [R04]
              end else begin
                next_s.period_buffer_valid = 1'b1; // see [R02]
              end
            end
          end
          default: next_s.ctrla = s.ctrla;
        endcase
      end
    end
    // capture queue: a read of a full compare register pops the buffer
    for (int i = 0; i < 4; i++) begin
      if (rd && cpten[i] && wb_i.adr[7:4] == ctbcd_pkg::ADR_CC_PAGE && ci == i[1:0]) begin
        if (s.compare_buffer_valid[i]) begin
          next_s.compare_channel[i] = s.compare_buffer[i]; // see [R10]
          next_s.compare_buffer_valid[i] = 1'b0;
        end else begin
          next_s.channel_match_flag[i] = 1'b0;
        end
      end
    end
    // start and retrigger events
    if (s.evctrl[ctbcd_pkg::E_EV0ACT +: 2] == ctbcd_pkg::EV0_RETRIGGER
        || s.evctrl[ctbcd_pkg::E_EV0ACT +: 2] == ctbcd_pkg::EV0_START) begin
      restart = restart | rise[0]; // see [R17]
    end
    // period and pulse-width capture on timer event 1
    pw_restart = s.evctrl[ctbcd_pkg::E_INV1] ? fall[1] : rise[1]; // see [R13]
    pw_other = s.evctrl[ctbcd_pkg::E_INV1] ? rise[1] : fall[1];
    for (int i = 0; i < 4; i++) begin
      cap[i] = s.evctrl[ctbcd_pkg::E_MCEI + i] & cpten[i] & rise[2 + i]; // see [R08] [R09]
    end
    if (s.evctrl[ctbcd_pkg::E_EV1ACT +: 2] == ctbcd_pkg::EV1_PERIOD_THEN_WIDTH) begin
      cap[1:0] = {pw_other, pw_restart} & s.evctrl[ctbcd_pkg::E_MCEI +: 2] & cpten[1:0]; // see [R12]
      restart = restart | pw_restart;
    end else if (s.evctrl[ctbcd_pkg::E_EV1ACT +: 2] == ctbcd_pkg::EV1_WIDTH_THEN_PERIOD) begin
      cap[1:0] = {pw_restart, pw_other} & s.evctrl[ctbcd_pkg::E_MCEI +: 2] & cpten[1:0]; // see [R12]
      restart = restart | pw_restart;
    end
    cap_val = s.count;
    if (mode == ctbcd_pkg::MODE_DSBOTH && top < ctbcd_pkg::MAX_HALF) begin
      cap_val[23] = s.ramp_down; // see [R14]
    end
    for (int i = 0; i < 4; i++) begin
      if (cap[i]) begin
        if (next_s.channel_match_flag[i] && next_s.compare_buffer_valid[i]) begin
          next_s.error_interrupt_flag = 1'b1; // see [R11] [R22]
        end else if (!next_s.channel_match_flag[i]) begin
          next_s.compare_channel[i] = cap_val; // see [R09]
          next_s.channel_match_flag[i] = 1'b1;
        end else begin
          next_s.compare_buffer[i] = cap_val; // see [R10]
          next_s.compare_buffer_valid[i] = 1'b1;
        end
      end
    end
    // counter run state
    unique case (s.run)
      ctbcd_pkg::RUN_IDLE: begin
        if (s.ctrla[ctbcd_pkg::A_EN]) begin
          next_s.run = ctbcd_pkg::RUN_COUNT;
        end
      end
      ctbcd_pkg::RUN_COUNT: begin
        if (mode == ctbcd_pkg::MODE_DSBOTH) begin
          if (!s.ramp_down) begin
            next_s.ramp_down = (s.count == top);
            next_s.count = (s.count == top) ? s.count - 24'h000001 : s.count + 24'h000001;
            upd = (s.count == top);
          end else if (s.count == 24'h000000) begin
            next_s.ramp_down = 1'b0;
            next_s.count = 24'h000001;
            wrap = 1'b1;
          end else begin
            next_s.count = s.count - 24'h000001;
          end
        end else if (!s.ctrlb[ctbcd_pkg::B_DIR]) begin
          wrap = (s.count == top); // see [R06]
          next_s.count = wrap ? 24'h000000 : s.count + 24'h000001;
        end else begin
          wrap = (s.count == 24'h000000);
          next_s.count = wrap ? top : s.count - 24'h000001;
        end
        upd = upd | wrap;
        if (wrap && s.ctrlb[ctbcd_pkg::B_SINGLE]) begin
          next_s.run = ctbcd_pkg::RUN_STOPPED; // see [R15]
          next_s.stop = 1'b1;
        end
        if (!s.ctrla[ctbcd_pkg::A_EN]) begin
          next_s.run = ctbcd_pkg::RUN_IDLE;
        end
      end
      ctbcd_pkg::RUN_STOPPED: begin
        if (!s.ctrla[ctbcd_pkg::A_EN]) begin
          next_s.run = ctbcd_pkg::RUN_IDLE;
        end
      end
    endcase
    if (wrap) begin
      next_s.ovf = 1'b1;
      next_s.frame = s.frame + 6'h01; // see [R19]
    end
    // waveform generation on compare channels
    for (int i = 0; i < 4; i++) begin
      cmp = (s.compare_channel[i] >> sh) + {23'h000000, extra_cycle(res, s.compare_channel[i], s.frame)};
      if (s.run == ctbcd_pkg::RUN_COUNT && !cpten[i]) begin
        if (freq_mode) begin
          next_s.wo[i] = s.wo[i] ^ wrap;
        end else if (mode == ctbcd_pkg::MODE_DSBOTH) begin
          if (s.count == cmp) begin
            next_s.wo[i] = ~s.ramp_down;
          end
        end else if (s.count == cmp) begin
          next_s.wo[i] = s.ctrlb[ctbcd_pkg::B_DIR];
        end else if (wrap) begin
          next_s.wo[i] = ~s.ctrlb[ctbcd_pkg::B_DIR];
        end
      end
    end
    // update condition: buffers into active registers
    if (upd && !s.ctrlb[ctbcd_pkg::B_LOCK]) begin
      if (s.wave[ctbcd_pkg::W_CIPER]) begin
        next_s.per = s.period_buffer; // see [R18]
        next_s.period_buffer = s.per;
        next_s.period_buffer_valid = 1'b0;
      end else if (s.period_buffer_valid) begin
        next_s.per = s.period_buffer; // see [R07]
        next_s.period_buffer_valid = 1'b0; // see [R02]
      end
      for (int i = 0; i < 4; i++) begin
        if (!cpten[i] && s.wave[ctbcd_pkg::W_CICC + i]) begin
          next_s.compare_channel[i] = s.compare_buffer[i]; // see [R18]
          next_s.compare_buffer[i] = s.compare_channel[i];
          next_s.compare_buffer_valid[i] = 1'b0;
        end else if (!cpten[i] && s.compare_buffer_valid[i]) begin
          next_s.compare_channel[i] = s.compare_buffer[i]; // see [R02]
          next_s.compare_buffer_valid[i] = 1'b0;
        end
      end
      if (s.waveform_buffer_valid) begin
        next_s.wave = s.waveform_control_buffer; // see [R01]
        next_s.waveform_buffer_valid = 1'b0;
      end
      if (s.pattern_buffer_valid) begin
        next_s.output_pattern = s.output_pattern_buffer; // see [R01]
        next_s.pattern_buffer_valid = 1'b0;
      end
    end
    // direct period write after the synchronisation delay
    if (s.per_pend) begin
      next_s.per_pend_cnt = s.per_pend_cnt - 2'h1;
      if (s.per_pend_cnt == 2'h1) begin
        next_s.per = s.per_pend_val; // see [R05]
        next_s.per_pend = 1'b0;
      end
    end
    // restart command or event
    if (restart && s.ctrla[ctbcd_pkg::A_EN]) begin
      next_s.run = ctbcd_pkg::RUN_COUNT; // see [R17]
      next_s.stop = 1'b0;
      next_s.ramp_down = 1'b0;
      next_s.count = s.ctrlb[ctbcd_pkg::B_DIR] ? top : 24'h000000;
    end
    // output select: halt state, then pattern, then waveform
    for (int i = 0; i < 4; i++) begin
      if (next_s.stop && s.drive_control[ctbcd_pkg::D_NRE + i]) begin
        next_s.out[i] = s.drive_control[ctbcd_pkg::D_NRV + i]; // see [R15]
      end else if (next_s.output_pattern[i]) begin
        next_s.out[i] = next_s.output_pattern[ctbcd_pkg::P_VAL + i];
      end else begin
        next_s.out[i] = next_s.wo[i];
      end
    end
    // synchronous reset
    if (rst_i) begin
      next_s = '0;
      next_s.run = ctbcd_pkg::RUN_IDLE;
      next_s.per = ctbcd_pkg::RST_PER;
    end
  end

  // state register
  always_ff @(posedge clk_i) begin
    s <= next_s;
  end

  // outputs straight from flops
  assign wb_dat_o = s.dat;
  assign wb_ack_o = s.ack;
  assign waveform_o = s.out;

endmodule : ctbcd_top

// ===== verification/ctbcd_events.sv
`timescale 1ns/1ps
// ************************************************************
// event channel model
// ************************************************************
module ctbcd_events (
  // clock
  input wire logic clk_i,
  // lines the bench wants raised
  input wire logic [5:0] fire_i,
  // event lines into the timer
  output logic [5:0] event_o
);
  // one private line per channel, all able to fire at once
  always_ff @(posedge clk_i) begin
    event_o <= fire_i;
  end
endmodule : ctbcd_events

// ===== verification/ctbcd_top_asserts.sv
`timescale 1ns/1ps
// ************************************************************
// bus and control checks
// ************************************************************
module ctbcd_top_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // bus and pins
  input ctbcd_pkg::ctbcd_wb_req_s wb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [5:0] event_i,
  input wire logic [3:0] waveform_o
);
  logic [2:0] ctrlb;
  logic rd;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // read answer in this cycle
  assign rd = wb_ack_o && !wb_i.we;
  // shadow of control b built from finished writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrlb <= 3'h0;
    end else if (wb_ack_o && wb_i.we && wb_i.adr == ctbcd_pkg::ADR_CTRLB_SET) begin
      ctrlb <= ctrlb | wb_i.dat[2:0];
    end else if (wb_ack_o && wb_i.we && wb_i.adr == ctbcd_pkg::ADR_CTRLB_CLR) begin
      ctrlb <= ctrlb & ~wb_i.dat[2:0];
    end
  end
  ack_follows_a: assert property (wb_i.cyc && wb_i.stb && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  ack_single_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_i.cyc && wb_i.stb))
    else $error("ack without request");
  ctrlb_read_a: assert property (rd && wb_i.adr[7:4] == 4'h0 && wb_i.adr[3:2] != 2'h0
    && wb_i.adr[3:2] != 2'h3 |-> wb_dat_o == {29'h0, ctrlb}) else $error("control b wrong");
  status_width_a: assert property (rd && wb_i.adr == ctbcd_pkg::ADR_STATUS |-> wb_dat_o[31:8] == 24'h0)
    else $error("status upper bits");
  flag_width_a: assert property (rd && wb_i.adr == ctbcd_pkg::ADR_INTFLAG
    |-> wb_dat_o[31:8] == 24'h0 && wb_dat_o[3:2] == 2'h0) else $error("flag upper bits");
  hole_zero_a: assert property (rd && wb_i.adr == 8'h38 |-> wb_dat_o == 32'h0) else $error("hole not zero");
  per_width_a: assert property (rd && wb_i.adr == ctbcd_pkg::ADR_PER |-> wb_dat_o[31:24] == 8'h0)
    else $error("period upper bits");
endmodule : ctbcd_top_asserts

// ===== verification/ctbcd_top_tb.sv
`timescale 1ns/1ps
module ctbcd_top_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  ctbcd_pkg::ctbcd_wb_req_s wb = '0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [5:0] fire = 6'h0;
  logic [5:0] event_i;
  logic [3:0] waveform_o;
  logic [31:0] d;
  logic [31:0] e;
  int fail_count = 0;
  int n_compared = 0;
  int ticks = 0;
  // ************************************************************
  // clock, watchdog, instances and tasks
  // ************************************************************
  always #10 clk_i = ~clk_i;
  // cut a hang short
  always @(posedge clk_i) begin
    ticks <= ticks + 1;
    if (ticks == 6000) begin
      fail_count++;
      close_out();
    end
  end
  ctbcd_top ctbcd_top_i (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .event_i(event_i), .waveform_o(waveform_o));
  ctbcd_events ctbcd_events_i (.clk_i(clk_i), .fire_i(fire), .event_o(event_i));
  task automatic close_out();
    if (fail_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_i);
    wb <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hf, dat: v};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    d = wb_dat_o;
    wb <= '0;
  endtask : bus
  task automatic rc(input logic [7:0] a, input logic [31:0] x, input logic [31:0] m = 32'hffffffff);
    bus(1'b0, a, 32'h0);
    chk(d & m, x);
  endtask : rc
  // main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rc(ctbcd_pkg::ADR_PER, 32'hffffff);
    bus(1'b1, ctbcd_pkg::ADR_CTRLB_SET, 32'h2);
    bus(1'b1, ctbcd_pkg::ADR_PER, 32'h80);
    bus(1'b1, ctbcd_pkg::ADR_PERIOD_BUFFER, 32'h40);
    repeat (4) @(posedge clk_i);
    rc(ctbcd_pkg::ADR_PER, 32'h80);
    rc(ctbcd_pkg::ADR_STATUS, 32'h0, 32'h2);
    rc(ctbcd_pkg::ADR_PERIOD_BUFFER, 32'h40);
    rc(8'h38, 32'h0);
    bus(1'b1, ctbcd_pkg::ADR_CTRLA, 32'h21);
    bus(1'b1, ctbcd_pkg::ADR_CTRLB_CLR, 32'h2);
    bus(1'b1, ctbcd_pkg::ADR_PERIOD_BUFFER, 32'h20);
    rc(ctbcd_pkg::ADR_STATUS, 32'h2, 32'h2);
    rc(ctbcd_pkg::ADR_PER, 32'h80);
    repeat (300) @(posedge clk_i);
    rc(ctbcd_pkg::ADR_STATUS, 32'h0, 32'h2);
    rc(ctbcd_pkg::ADR_PER, 32'h20);
    bus(1'b1, ctbcd_pkg::ADR_CTRLA, 32'h01);
    bus(1'b1, ctbcd_pkg::ADR_PERIOD_BUFFER, 32'h30);
    rc(ctbcd_pkg::ADR_PER, 32'h30);
    bus(1'b1, ctbcd_pkg::ADR_CTRLA, 32'h21);
    bus(1'b1, ctbcd_pkg::ADR_WAVE, 32'h1);
    bus(1'b1, ctbcd_pkg::ADR_PERIOD_BUFFER, 32'h50);
    repeat (200) @(posedge clk_i);
    bus(1'b1, ctbcd_pkg::ADR_CTRLA, 32'h100);
    bus(1'b0, ctbcd_pkg::ADR_PER, 32'h0);
    e = d;
    rc(ctbcd_pkg::ADR_PERIOD_BUFFER, 32'h80 - e);
    chk({31'h0, e == 32'h30 || e == 32'h50}, 32'h1);
    bus(1'b1, ctbcd_pkg::ADR_WAVE, 32'h0);
    bus(1'b1, ctbcd_pkg::ADR_PERIOD_BUFFER, 32'hffffff);
    bus(1'b1, ctbcd_pkg::ADR_EVCTRL, 32'h100);
    bus(1'b1, ctbcd_pkg::ADR_CTRLA, 32'h101);
    repeat (3) begin
      fire <= 6'h4;
      repeat (4) @(posedge clk_i);
      fire <= 6'h0;
      repeat (36) @(posedge clk_i);
    end
    rc(ctbcd_pkg::ADR_INTFLAG, 32'h12, 32'h12);
    rc(ctbcd_pkg::ADR_STATUS, 32'h10, 32'h10);
    bus(1'b0, 8'h40, 32'h0);
    e = d;
    bus(1'b0, 8'h40, 32'h0);
    chk(d - e, 32'h28);
    rc(ctbcd_pkg::ADR_STATUS, 32'h0, 32'h10);
    bus(1'b1, ctbcd_pkg::ADR_DRV, 32'h50f);
    bus(1'b1, ctbcd_pkg::ADR_PERIOD_BUFFER, 32'h10);
    bus(1'b1, ctbcd_pkg::ADR_CTRLB_SET, 32'hc);
    repeat (40) @(posedge clk_i);
    rc(ctbcd_pkg::ADR_STATUS, 32'h1, 32'h1);
    chk({28'h0, waveform_o}, 32'h5);
    bus(1'b1, ctbcd_pkg::ADR_CTRLB_SET, 32'h8);
    rc(ctbcd_pkg::ADR_STATUS, 32'h0, 32'h1);
    bus(1'b1, ctbcd_pkg::ADR_CTRLB_CLR, 32'h4);
    rc(ctbcd_pkg::ADR_CTRLB_SET, 32'h0, 32'h4);
    close_out();
  end
endmodule : ctbcd_top_tb
bind ctbcd_top ctbcd_top_asserts ctbcd_top_asserts_i (.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .event_i(event_i), .waveform_o(waveform_o));
